// [dlc_defs.vh]
// dlc_defs.vh: constants for the dialer line control block.
// assumes: included by bare name; definitions only, no logic.
`ifndef DLC_DEFS_VH
`define DLC_DEFS_VH

// ****************************************************************
// register indices and byte addresses (byte address = 4 x index)
// ****************************************************************
`define DLC_IDX_DIALER      8'h16
`define DLC_IDX_LINE        8'h22
`define DLC_IDX_TICK        8'h24
`define DLC_ADDR_DIALER     12'h058
`define DLC_ADDR_LINE       12'h088
`define DLC_ADDR_TICK       12'h090
`define DLC_ADDR_IRQ        12'h0A0

// ****************************************************************
// field positions
// ****************************************************************
`define DLC_B_HF_IN         0
`define DLC_B_HF_OUT        1
`define DLC_B_HD_IN         2
`define DLC_B_HD_OUT        3
`define DLC_B_HOOK          4
`define DLC_B_AUTO_SEL      5
`define DLC_B_DIAL_BRK      6
`define DLC_B_MUTE          7
`define DLC_B_LINE_EN       7
`define DLC_B_TICK_EN       5
`define DLC_B_TICK_TO       7
`define DLC_B_IRQ_TICK      0
`define DLC_B_IRQ_DIALER    1

// ****************************************************************
// reset values and operating modes
// ****************************************************************
`define DLC_RST_AUTO_SEL    1'b0
`define DLC_RST_DIAL_BRK    1'b1
`define DLC_RST_MUTE        1'b1
`define DLC_RST_SYNC        3'h5
`define DLC_RST_LINE        1'b0
`define DLC_RST_TICK        1'b0
`define DLC_MODE_NORMAL     2'h0
`define DLC_MODE_GREEN      2'h1
`define DLC_MODE_SLEEP      2'h2
`define DLC_MODE_IDLE       2'h3

// ****************************************************************
// timing
// ****************************************************************
`define DLC_CLK_HZ          100000000
`define DLC_TICK_MS         1000
`define DLC_TICK_CYCLES     (`DLC_CLK_HZ / 1000 * `DLC_TICK_MS)

`endif

// [dlc_tick.v]
// dlc_tick.v: periodic time-out counter for the clock tick function.
// assumes: sys_clk at 100 MHz, rst_b asynchronous active low, ce freezes.
`timescale 1ns/1ps
`include "dlc_defs.vh"

module dlc_tick #(
    parameter PERIOD = `DLC_TICK_CYCLES
) (
    input  wire sys_clk,
    input  wire rst_b,
    input  wire ce,
    input  wire enable,
    output reg  timeout_q
);
    reg [31:0] cnt_q;

    // ****************************************************************
    // counter
    // ****************************************************************
    // one-cycle pulse each full period; disabling restarts the period
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q     <= 32'h0;
            timeout_q <= 1'b0;
        end else if (ce) begin
            timeout_q <= 1'b0;
            if (!enable) begin
                cnt_q <= 32'h0;
            end else if (cnt_q >= PERIOD - 1) begin
                cnt_q     <= 32'h0;
                timeout_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule

// [dlc_line_ctrl.v]
// dlc_line_ctrl.v: dialer pins, line control and clock tick registers on apb.
// assumes: hook, hands-free and hold pins synchronised here; other inputs synchronous to sys_clk; a single apb master.
//
// Operation
// - status bits 0..4 show hands-free in/out, hold in/out, hook levels.
// - auto-select bit 5 lets pins drive line; zero leaves line output to line control only.
// - bit 6 floats dial break output when 1, pulls low when 0.
// - bit 7 floats speech mute output when 1, drives low when 0.
// - auto-select result low only when hook high and both outputs low.
// - line control register bit 7 is enable; bits 6..0 read zero.
// - source is tick in normal/green, wake or tick in sleep, wake idle.
// - active line control source drives line output high.
// - writing zero to enable ends line control; line output then follows auto-select only.
// - tick register has enable bit 5, time-out flag bit 7, rest zero.
// - enabled tick counter times out every 1000 ms.
// - each time-out sets tick interrupt flag and time-out flag.
// - servicing clears interrupt flag; time-out flag kept until software.
// - a left-set time-out flag does not block the next interrupt.
// - hook rising edge gives on-hook status and dialer interrupt.
// - hook falling edge gives off-hook, clears both outputs, interrupts.
// - hold low pulse while line made clears hands-free, toggles hold.
// - hands-free high pulse clears hold, toggles hands-free, interrupts.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "dlc_defs.vh"

module dlc_line_ctrl #(
    parameter TICK_CYCLES = `DLC_TICK_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        hook_switch_in,
    input  wire        handsfree_req_in,
    input  wire        hold_req_in,
    input  wire [1:0]  op_mode,
    input  wire        port_wake,
    input  wire        tick_irq_ack,
    input  wire        dialer_irq_ack,
    output reg         handsfree_out,
    output reg         hold_line_out,
    output reg         line_drive_out,
    output reg         dial_break_out,
    output reg         dial_break_oe_b,
    output reg         speech_mute_out,
    output reg         speech_mute_oe_b,
    output reg         clock_tick_irq_flag,
    output reg         dialer_irq_flag,
    output reg         on_hook_status
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    // input pipeline: two synchroniser stages and the edge register
    reg  [2:0] sync1_q;
    reg  [2:0] sync2_q;
    reg  [2:0] prev_q;

    // software flags of the dialer, line control and tick registers
    reg        line_auto_sel;
    reg        dial_break_ctrl;
    reg        mute_ctrl;
    reg        line_hold_enable;
    reg        clock_tick_enable;
    reg        clock_tick_timeout_flag;

    // line control latch, set by its source and cleared by the enable
    reg        line_active_q;

    // next values of the dialer outputs and the line pin
    reg        hf_d;
    reg        hd_d;
    reg        line_d;
    reg        auto_line;
    reg        src_hit;

    // read data chosen in the setup phase
    reg [31:0] rdata_d;

    // tick pulse from the counter
    wire       tick_to;

    // synchronised pin levels
    wire       hook_s;
    wire       hf_s;
    wire       hd_s;

    // bus strobes
    wire       wr_en;
    wire       rd_en;

    // one-cycle pin events
    wire       hook_rise;
    wire       hook_fall;
    wire       hd_pulse;
    wire       hf_pulse;

    // address decode used for the error answer; the read mux decodes on its own
    // the irq flag word has an offset of its own beside the three registers
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `DLC_ADDR_DIALER) || (a == `DLC_ADDR_LINE) ||
                     (a == `DLC_ADDR_TICK) || (a == `DLC_ADDR_IRQ);
        end
    endfunction

    // ****************************************************************
    // clock tick counter
    // ****************************************************************
    // a disabled counter holds at zero, so enabling starts a full period
    dlc_tick #(
        .PERIOD    (TICK_CYCLES)
    ) u_tick (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .enable    (clock_tick_enable),
        .timeout_q (tick_to)
    );

    // ****************************************************************
    // input synchronisers: hook, hands-free, hold
    // ****************************************************************
    // two stages then an edge register; only sync2 feeds the detectors
    // reset to the idle levels: hook up, hands-free low, hold high
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= `DLC_RST_SYNC;
            sync2_q <= `DLC_RST_SYNC;
            prev_q  <= `DLC_RST_SYNC;
        end else if (ce) begin
            sync1_q <= {hold_req_in, handsfree_req_in, hook_switch_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end
    // synchronised levels, also shown in the status register
    assign hook_s    = sync2_q[0];
    assign hf_s      = sync2_q[1];
    assign hd_s      = sync2_q[2];

    // hook changes act on both edges
    assign hook_rise = hook_s & ~prev_q[0];
    assign hook_fall = ~hook_s & prev_q[0];
    // hold request ends on its rising edge; hands-free on its falling edge
    assign hd_pulse  = hd_s & ~prev_q[2];
    assign hf_pulse  = ~hf_s & prev_q[1];

    assign wr_en = psel & penable & pwrite & ce;
    assign rd_en = psel & ~penable & ~pwrite;

    // ****************************************************************
    // dialer state machine next values
    // ****************************************************************
    // hook fall outranks hold, and hold outranks hands-free
    always @* begin
        hf_d = handsfree_out;
        hd_d = hold_line_out;
        if (hook_fall) begin
            hf_d = 1'b0;
            hd_d = 1'b0;
        end else if (hd_pulse && line_drive_out) begin
            hf_d = 1'b0;
            hd_d = ~hold_line_out;
        end else if (hf_pulse) begin
            hd_d = 1'b0;
            hf_d = ~handsfree_out;
        end
        // line breaks only with hook up and neither hold nor hands-free
        auto_line = ~(hook_s & ~hf_d & ~hd_d);

        // source selection by operating mode
        case (op_mode)
            `DLC_MODE_NORMAL: src_hit = tick_to;
            `DLC_MODE_GREEN:  src_hit = tick_to;
            `DLC_MODE_SLEEP:  src_hit = tick_to | port_wake;
            `DLC_MODE_IDLE:   src_hit = port_wake;
            default:          src_hit = 1'b0;
        endcase
        line_d = (line_auto_sel & auto_line) | line_active_q;
    end

    // ****************************************************************
    // dialer outputs and line control
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            handsfree_out   <= 1'b0;
            hold_line_out   <= 1'b0;
            line_drive_out  <= 1'b0;
            line_active_q   <= 1'b0;
            on_hook_status  <= 1'b1;
            dialer_irq_flag <= 1'b0;
        end else if (ce) begin
            // outputs take their next values on every enabled edge
            handsfree_out  <= hf_d;
            hold_line_out  <= hd_d;
            line_drive_out <= line_d;
            if (hook_rise) begin
                on_hook_status <= 1'b1;
            end else if (hook_fall) begin
                on_hook_status <= 1'b0;
            end

            // line control latches on its source and ends with the enable
            if (!line_hold_enable) begin
                line_active_q <= 1'b0;
            end else if (src_hit) begin
                line_active_q <= 1'b1;
            end

            // set wins over acknowledge
            if (hook_rise || hook_fall || (hd_pulse && line_drive_out) || hf_pulse) begin
                dialer_irq_flag <= 1'b1;
            end else if (dialer_irq_ack) begin
                dialer_irq_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_auto_sel           <= `DLC_RST_AUTO_SEL;
            dial_break_ctrl         <= `DLC_RST_DIAL_BRK;
            mute_ctrl               <= `DLC_RST_MUTE;
            line_hold_enable        <= `DLC_RST_LINE;
            clock_tick_enable       <= `DLC_RST_TICK;
            clock_tick_timeout_flag <= 1'b0;
            clock_tick_irq_flag     <= 1'b0;
        end else if (ce) begin
            // dialer flags; status bits 0..4 are read-only, writes to them drop
            if (wr_en && paddr == `DLC_ADDR_DIALER) begin
                line_auto_sel   <= pwdata[`DLC_B_AUTO_SEL];
                dial_break_ctrl <= pwdata[`DLC_B_DIAL_BRK];
                mute_ctrl       <= pwdata[`DLC_B_MUTE];
            end

            // line control enable; clearing it ends a latched line
            if (wr_en && paddr == `DLC_ADDR_LINE) begin
                line_hold_enable <= pwdata[`DLC_B_LINE_EN];
            end

            // tick enable; the counter restarts its period when cleared
            if (wr_en && paddr == `DLC_ADDR_TICK) begin
                clock_tick_enable <= pwdata[`DLC_B_TICK_EN];
            end

            // time-out sets the flag whatever its old value; set wins over write
            if (tick_to) begin
                clock_tick_timeout_flag <= 1'b1;
            end else if (wr_en && paddr == `DLC_ADDR_TICK) begin
                clock_tick_timeout_flag <= pwdata[`DLC_B_TICK_TO];
            end
            // interrupt service clears only the request flag
            if (tick_to) begin
                clock_tick_irq_flag <= 1'b1;
            end else if (tick_irq_ack) begin
                clock_tick_irq_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // open-drain pins: enable low while pulling low
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dial_break_out   <= 1'b0;
            dial_break_oe_b  <= 1'b1;
            speech_mute_out  <= 1'b0;
            speech_mute_oe_b <= 1'b1;
        end else if (ce) begin
            // the data side stays low; only the enable moves
            dial_break_out   <= 1'b0;
            dial_break_oe_b  <= dial_break_ctrl;
            speech_mute_out  <= 1'b0;
            speech_mute_oe_b <= mute_ctrl;
        end
    end

    // ****************************************************************
    // apb read mux
    // ****************************************************************
    always @* begin
        // unused bits and unmapped offsets read as zero
        rdata_d = 32'h0;
        case (paddr)
            `DLC_ADDR_DIALER: begin
                rdata_d[`DLC_B_HF_IN]    = hf_s;
                rdata_d[`DLC_B_HF_OUT]   = handsfree_out;
                rdata_d[`DLC_B_HD_IN]    = hd_s;
                rdata_d[`DLC_B_HD_OUT]   = hold_line_out;
                rdata_d[`DLC_B_HOOK]     = hook_s;
                rdata_d[`DLC_B_AUTO_SEL] = line_auto_sel;
                rdata_d[`DLC_B_DIAL_BRK] = dial_break_ctrl;
                rdata_d[`DLC_B_MUTE]     = mute_ctrl;
            end
            `DLC_ADDR_LINE: rdata_d[`DLC_B_LINE_EN] = line_hold_enable;
            `DLC_ADDR_TICK: begin
                rdata_d[`DLC_B_TICK_EN] = clock_tick_enable;
                rdata_d[`DLC_B_TICK_TO] = clock_tick_timeout_flag;
            end
            // the irq flag word shows both request flags
            `DLC_ADDR_IRQ: begin
                rdata_d[`DLC_B_IRQ_TICK]   = clock_tick_irq_flag;
                rdata_d[`DLC_B_IRQ_DIALER] = dialer_irq_flag;
            end
            default: rdata_d = 32'h0;
        endcase
    end

    // ****************************************************************
    // apb answer: no wait state, ready in first access cycle
    // ****************************************************************
    // data captured in setup so the access phase sees a registered answer
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            // every setup is answered at once, so the access phase never waits
            pready  <= psel & ~penable;
            // an unmapped offset still completes, flagged as an error
            pslverr <= psel & ~penable & ~mapped(paddr);

            if (rd_en) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule

// [dlc_line_ctrl_chk.sv]
// dlc_line_ctrl_chk.sv: port assertions for the dialer line control block.
// assumes: bound from the bench top; ce held high.
`timescale 1ns/1ps
`include "dlc_defs.vh"
module dlc_line_ctrl_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        hook_switch_in,
    input wire logic        handsfree_out,
    input wire logic        hold_line_out,
    input wire logic        line_drive_out,
    input wire logic        dial_break_oe_b,
    input wire logic        speech_mute_oe_b,
    input wire logic        clock_tick_irq_flag,
    input wire logic        dialer_irq_flag,
    input wire logic        on_hook_status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ****************************************************************
    // mirrors of the software flags, taken from completed writes
    // ****************************************************************
    logic auto_q, brk_q, mute_q, lnen_q, tken_q;
    wire  wr_ok = psel && penable && pready && pwrite;
    wire  rd_ok = psel && penable && pready && !pwrite;
    // reset values follow the design: floating pins, everything else off
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {mute_q, brk_q, auto_q, lnen_q, tken_q} <= 5'h18;
        end else if (wr_ok && paddr == `DLC_ADDR_DIALER) begin
            {mute_q, brk_q, auto_q} <= pwdata[7:5];
        end else if (wr_ok && paddr == `DLC_ADDR_LINE) begin
            lnen_q <= pwdata[7];
        end else if (wr_ok && paddr == `DLC_ADDR_TICK) begin
            tken_q <= pwdata[5];
        end
    end
    property p_line_off; (!auto_q && !lnen_q) [*3] |=> !line_drive_out; endproperty
    a_line_off: assert property (p_line_off) else $error("line made while off");
    property p_brk; $stable(brk_q) [*2] |-> dial_break_oe_b == brk_q; endproperty
    a_brk: assert property (p_brk) else $error("dial break pin wrong");
    property p_mute; $stable(mute_q) [*2] |-> speech_mute_oe_b == mute_q; endproperty
    a_mute: assert property (p_mute) else $error("mute pin wrong");
    property p_line_rd;
        rd_ok && paddr == `DLC_ADDR_LINE |-> prdata[31:8] == 24'h0 && prdata[6:0] == 7'h0;
    endproperty
    a_line_rd: assert property (p_line_rd) else $error("line unused bits set");
    property p_tick_rd;
        rd_ok && paddr == `DLC_ADDR_TICK |-> prdata[31:8] == 24'h0 && !prdata[6]
            && prdata[4:0] == 5'h0;
    endproperty
    a_tick_rd: assert property (p_tick_rd) else $error("tick unused bits set");
    property p_tick_en; $rose(clock_tick_irq_flag) |-> $past(tken_q); endproperty
    a_tick_en: assert property (p_tick_en) else $error("tick while disabled");
    property p_on_hook;
        $rose(hook_switch_in) |-> ##[3:5] (on_hook_status && dialer_irq_flag);
    endproperty
    a_on_hook: assert property (p_on_hook) else $error("on-hook missed");
    property p_off_hook;
        $fell(hook_switch_in) |-> ##[3:5] (!on_hook_status && !handsfree_out && !hold_line_out);
    endproperty
    a_off_hook: assert property (p_off_hook) else $error("off-hook missed");
    c_tick: cover property ($rose(clock_tick_irq_flag));
    c_hook: cover property ($fell(hook_switch_in));
    c_line: cover property (lnen_q && line_drive_out);
endmodule

// [dlc_phone_model.sv]
// dlc_phone_model.sv: hook switch and line circuit seen by the dialer pins.
// assumes: open-drain pins have pull-ups on the line side.
`timescale 1ns/1ps
module dlc_phone_model (
    input  wire logic sys_clk,
    input  wire logic dial_break_out,
    input  wire logic dial_break_oe_b,
    input  wire logic speech_mute_out,
    input  wire logic speech_mute_oe_b,
    output var  logic hook_switch_in,
    output var  logic handsfree_req_in,
    output var  logic hold_req_in,
    output wire logic dial_pin,
    output wire logic mute_pin
);
    // ****************************************************************
    // pins
    // ****************************************************************
    // request pins start at their idle levels: on hook, no request
    initial begin
        hook_switch_in   = 1'b1;
        handsfree_req_in = 1'b0;
        hold_req_in      = 1'b1;
    end
    // a floating pin reads as the pull-up level
    assign dial_pin = dial_break_oe_b ? 1'b1 : dial_break_out;
    assign mute_pin = speech_mute_oe_b ? 1'b1 : speech_mute_out;
    // pulses last 4 cycles, four times the one-cycle minimum width
    task automatic pulse(input logic hf);
        @(posedge sys_clk);
        handsfree_req_in <= hf;
        hold_req_in <= hf;
        repeat (4) @(posedge sys_clk);
        handsfree_req_in <= 1'b0;
        hold_req_in <= 1'b1;
    endtask
    task automatic hook(input logic v);
        @(posedge sys_clk) hook_switch_in <= v;
    endtask
endmodule

// [dlc_line_ctrl_tb.sv]
// dlc_line_ctrl_tb.sv: self-checking bench for the dialer line control block.
// assumes: design files and dlc_defs.vh on the include path.
`timescale 1ns/1ps
`include "dlc_defs.vh"
module dlc_line_ctrl_tb;
    localparam int TICK = 40;
    localparam logic [11:0] DIA = `DLC_ADDR_DIALER;
    localparam logic [11:0] LIN = `DLC_ADDR_LINE;
    localparam logic [11:0] TCK = `DLC_ADDR_TICK;
    // step: {event, hands-free, hold, line, dialer irq}
    logic [5:0] steps [7] = '{6'h09, 6'h17, 6'h23, 6'h0B, 6'h3B, 6'h01, 6'h10};
    logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic tick_irq_ack = 1'b0, dialer_irq_ack = 1'b0, port_wake = 1'b0, perr;
    logic [1:0] op_mode = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, hook_switch_in, handsfree_req_in, hold_req_in, handsfree_out;
    logic hold_line_out, line_drive_out, dial_break_out, dial_break_oe_b, speech_mute_out;
    logic speech_mute_oe_b, clock_tick_irq_flag, dialer_irq_flag, on_hook_status;
    logic dial_pin, mute_pin;
    int mismatches = 0, n_checks = 0, cyc = 0, t1, t2;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    dlc_line_ctrl #(.TICK_CYCLES(TICK)) i_dlc_line_ctrl (.sys_clk, .rst_b, .ce(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .hook_switch_in, .handsfree_req_in, .hold_req_in, .op_mode, .port_wake,
        .tick_irq_ack, .dialer_irq_ack, .handsfree_out, .hold_line_out, .line_drive_out,
        .dial_break_out, .dial_break_oe_b, .speech_mute_out, .speech_mute_oe_b,
        .clock_tick_irq_flag, .dialer_irq_flag, .on_hook_status);
    dlc_phone_model i_dlc_phone_model (.sys_clk, .dial_break_out, .dial_break_oe_b,
        .speech_mute_out, .speech_mute_oe_b, .hook_switch_in, .handsfree_req_in,
        .hold_req_in, .dial_pin, .mute_pin);
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) chk(32'h0, 32'h1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic ack(input logic t);
        @(posedge sys_clk);
        {tick_irq_ack, dialer_irq_ack} <= t ? 2'b10 : 2'b01;
        @(posedge sys_clk);
        {tick_irq_ack, dialer_irq_ack} <= 2'b00;
    endtask
    // wait for the tick flag; bounded so a dead counter cannot hang
    task automatic wt(output int c);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (clock_tick_irq_flag !== 1'b1 && n < 200);
        c = cyc;
        if (n == 200) chk(32'h0, 32'h1);
    endtask
    task automatic lc(input logic e);
        repeat (4) @(posedge sys_clk);
        chk({31'h0, line_drive_out}, {31'h0, e});
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(DIA, 32'hD4);
        rd(LIN, 32'h0);
        rd(TCK, 32'h0);
        apb(1'b1, 12'h0FC, 32'hFF);
        rd(12'h0FC, 32'h0);
        chk({31'h0, perr}, 32'h1);
        // pin events; auto-select goes on after the first one
        foreach (steps[i]) begin
            if (i == 1) apb(1'b1, DIA, 32'hE0);
            case (steps[i][5:4])
                2'd0: i_dlc_phone_model.pulse(1'b1);
                2'd1: i_dlc_phone_model.pulse(1'b0);
                default: i_dlc_phone_model.hook(steps[i][4]);
            endcase
            repeat (6) @(posedge sys_clk);
            chk({27'h0, on_hook_status, handsfree_out, hold_line_out, line_drive_out,
                dialer_irq_flag}, {27'h0, hook_switch_in, steps[i][3:0]}
            );
            ack(1'b0);
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, DIA, i ? 32'hE0 : 32'h20);
            repeat (3) @(posedge sys_clk);
            chk({30'h0, dial_pin, mute_pin}, {30'h0, i[0], i[0]});
            rd(DIA, i ? 32'hF4 : 32'h34);
        end
        apb(1'b1, TCK, 32'h20);
        wt(t1);
        rd(TCK, 32'hA0);
        rd(`DLC_ADDR_IRQ, 32'h1);
        ack(1'b1);
        @(posedge sys_clk);
        chk({31'h0, clock_tick_irq_flag}, 32'h0);
        rd(TCK, 32'hA0);
        wt(t2);
        chk(32'(t2 - t1), 32'(TICK));
        apb(1'b1, TCK, 32'h20);
        rd(TCK, 32'h20);
        // each mode: wake source first, then the tick source
        for (int m = 0; m < 4; m++) begin
            op_mode <= 2'(m);
            ack(1'b1);
            wt(t1);
            apb(1'b1, LIN, 32'h80);
            @(posedge sys_clk) port_wake <= 1'b1;
            @(posedge sys_clk) port_wake <= 1'b0;
            lc(m > 1);
            apb(1'b1, LIN, 32'h0);
            lc(1'b0);
            apb(1'b1, LIN, 32'h80);
            ack(1'b1);
            wt(t1);
            lc(m != 3);
            apb(1'b1, LIN, 32'h0);
        end
        conclude();
    end
endmodule
bind dlc_line_ctrl dlc_line_ctrl_chk i_dlc_line_ctrl_chk (.sys_clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .hook_switch_in,
    .handsfree_out, .hold_line_out, .line_drive_out, .dial_break_oe_b,
    .speech_mute_oe_b, .clock_tick_irq_flag, .dialer_irq_flag, .on_hook_status);
